/* File: rtl/dtu_edge_sync.sv */
// Two-flop synchroniser with selectable edge detector for one timer clock source.
// Assumes the source is asynchronous to sys_clk and much slower than it.
module dtu_edge_sync (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic nrst,
  // Source and edge choice.
  input wire logic src_in,
  input wire logic fall_sel,
  // Synchronised level and edge pulse.
  output logic level_out,
  output logic edge_pulse
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= src_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level_out = sync_reg;
  assign edge_pulse = fall_sel ? (prev_reg & ~sync_reg) : (~prev_reg & sync_reg);
endmodule : dtu_edge_sync

/* File: rtl/dtu_pkg.sv */
// Package for the dual timer unit: register offsets, bit positions and reset values.
// Assumes a 32-bit Avalon-MM slave with byte addresses, one register per aligned word.
package dtu_pkg;
  localparam logic [5:0] OFS_POWER_CTRL = 6'h00;
  localparam logic [5:0] OFS_UP_MODE = 6'h04;
  localparam logic [5:0] OFS_UP_COUNT = 6'h08;
  localparam logic [5:0] OFS_DOWN_CTRL_A = 6'h0c;
  localparam logic [5:0] OFS_DOWN_CTRL_B = 6'h10;
  localparam logic [5:0] OFS_RELOAD_HIGH = 6'h14;
  localparam logic [5:0] OFS_RELOAD_LOW = 6'h18;
  localparam logic [5:0] OFS_DOWN_PRE_CNT = 6'h1c;
  localparam logic [5:0] OFS_IRQ_ENABLE = 6'h20;
  localparam logic [5:0] OFS_IRQ_FLAG = 6'h24;
  // Power/control register bits.
  localparam int BIT_UP_RUN = 0;
  localparam int BIT_GIE = 7;
  // Up timer mode register bits.
  localparam int BIT_UP_LOWCLK = 7;
  localparam int BIT_UP_SRC = 5;
  localparam int BIT_UP_EDGE = 4;
  localparam int BIT_PRE_ASSIGN = 3;
  // Down timer control A bits.
  localparam int BIT_DN_HIRC = 3;
  localparam int BIT_DN_ONESHOT = 2;
  localparam int BIT_DN_RELOAD = 1;
  localparam int BIT_DN_RUN = 0;
  // Down timer control B bits.
  localparam int BIT_DN_SRC = 5;
  localparam int BIT_DN_EDGE = 4;
  localparam int BIT_DN_PRE_EN_N = 3;
  // Reload high bits and interrupt bits.
  localparam int BIT_RLD_HI = 4;
  localparam int BIT_IRQ_UP = 0;
  localparam int BIT_IRQ_DOWN = 3;
  // Reset values and the down counter full-scale reload value.
  localparam logic [7:0] RST_POWER_CTRL = 8'h00;
  localparam logic [7:0] RST_UP_MODE = 8'h08;
  localparam logic [7:0] RST_DOWN_CTRL_A = 8'h00;
  localparam logic [7:0] RST_DOWN_CTRL_B = 8'h08;
  localparam logic [9:0] DOWN_FULL_SCALE = 10'h3ff;
endpackage : dtu_pkg

/* File: rtl/dtu_prescaler.sv */
// Power-of-two prescaler: counts input ticks and emits one tick per 2^(ratio+1).
// Assumes tick_in is a one-cycle pulse in the sys_clk domain.
module dtu_prescaler #(
  parameter int WIDTH = 8
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic nrst,
  // Control.
  input wire logic clear,
  input wire logic [2:0] ratio,
  input wire logic tick_in,
  // Outputs.
  output logic tick_out,
  output logic [WIDTH-1:0] count
);
  logic [WIDTH-1:0] mask;

  // Ratio 0 gives 1:2, ratio 7 gives 1:256.
  assign mask = WIDTH'((9'h002 << ratio) - 9'h001);
  assign tick_out = tick_in && ((count & mask) == mask);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
    end else if (clear) begin
      count <= '0;
    end else if (tick_in) begin
      count <= count + WIDTH'(1);
    end
  end
endmodule : dtu_prescaler

/* File: rtl/dtu_timer_unit.sv */
// Dual timer unit: an 8-bit up timer with shared prescaler and a 10-bit down timer.
// Assumes an Avalon-MM master on sys_clk, and asynchronous pin and oscillator clocks.
//
// Local design decisions: the address map and register access over Avalon-MM.
module dtu_timer_unit
  import dtu_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic nrst,
  // Avalon-MM slave.
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Clock sources.
  input wire logic instr_clk_tick,
  input wire logic ext_timer_clk_pin,
  input wire logic internal_low_rc_osc,
  input wire logic internal_high_rc_osc,
  // Outputs to other blocks.
  output logic up_timer_irq,
  output logic down_timer_irq,
  output logic down_timer_unf,
  output logic shared_prescaler_tick
);
  logic [7:0] power_ctrl_reg;
  logic [7:0] up_timer_mode_reg;
  logic [7:0] down_timer_ctrl_a;
  logic [7:0] down_timer_ctrl_b;
  logic [7:0] reload_high_bits;
  logic [7:0] down_reload_low;
  logic [9:0] reload_buf_reg;
  logic [7:0] up_count_reg;
  logic [9:0] down_count_reg;
  logic down_done_reg;
  logic [7:0] irq_flag_reg;
  logic [7:0] irq_enable_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;

  logic wr_en;
  logic wr_low_lane;
  logic up_timer_run;
  logic up_timer_src_sel;
  logic up_timer_lowclk_sel;
  logic up_timer_edge_sel;
  logic shared_prescaler_assign;
  logic [2:0] shared_prescaler_ratio;
  logic down_timer_run;
  logic down_timer_hirc_sel;
  logic down_timer_oneshot;
  logic down_timer_reload_sel;
  logic down_timer_src_sel;
  logic down_timer_edge_sel;
  logic down_prescaler_en_n;
  logic [2:0] down_prescaler_ratio;
  logic [7:0] down_prescaler_count;
  logic global_irq_en;
  logic pin_fall_edge;
  logic pin_rise_edge;
  logic lrc_fall_edge;
  logic lrc_rise_edge;
  logic hrc_edge;
  logic up_src_tick;
  logic up_pre_tick;
  logic up_tick;
  logic down_src_tick;
  logic down_pre_tick;
  logic down_tick;
  logic up_ovf;
  logic down_unf;
  logic pre_clear;
  logic [7:0] up_count_next;
  logic [9:0] down_count_next;

  assign up_timer_run = power_ctrl_reg[BIT_UP_RUN];
  assign global_irq_en = power_ctrl_reg[BIT_GIE];
  assign up_timer_lowclk_sel = up_timer_mode_reg[BIT_UP_LOWCLK];
  assign up_timer_src_sel = up_timer_mode_reg[BIT_UP_SRC];
  assign up_timer_edge_sel = up_timer_mode_reg[BIT_UP_EDGE];
  assign shared_prescaler_assign = up_timer_mode_reg[BIT_PRE_ASSIGN];
  assign shared_prescaler_ratio = up_timer_mode_reg[2:0];
  assign down_timer_hirc_sel = down_timer_ctrl_a[BIT_DN_HIRC];
  assign down_timer_oneshot = down_timer_ctrl_a[BIT_DN_ONESHOT];
  assign down_timer_reload_sel = down_timer_ctrl_a[BIT_DN_RELOAD];
  assign down_timer_run = down_timer_ctrl_a[BIT_DN_RUN];
  assign down_timer_src_sel = down_timer_ctrl_b[BIT_DN_SRC];
  assign down_timer_edge_sel = down_timer_ctrl_b[BIT_DN_EDGE];
  assign down_prescaler_en_n = down_timer_ctrl_b[BIT_DN_PRE_EN_N];
  assign down_prescaler_ratio = down_timer_ctrl_b[2:0];

  // Every access answers one cycle after it is presented.
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign wr_en = avs_write & ~avs_waitrequest;
  assign wr_low_lane = wr_en & avs_byteenable[0];
  assign avs_readdata = rdata_reg;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
    end
  end

  // The one pin feeds both timers, each edge sense synchronised once.
  dtu_edge_sync u_pin_fall (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .src_in(ext_timer_clk_pin),
    .fall_sel(1'b1),
    .level_out(),
    .edge_pulse(pin_fall_edge)
  );

  dtu_edge_sync u_pin_rise (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .src_in(ext_timer_clk_pin),
    .fall_sel(1'b0),
    .level_out(),
    .edge_pulse(pin_rise_edge)
  );

  dtu_edge_sync u_lrc_fall (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .src_in(internal_low_rc_osc),
    .fall_sel(1'b1),
    .level_out(),
    .edge_pulse(lrc_fall_edge)
  );

  dtu_edge_sync u_lrc_rise (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .src_in(internal_low_rc_osc),
    .fall_sel(1'b0),
    .level_out(),
    .edge_pulse(lrc_rise_edge)
  );

  // High RC faster than sys_clk loses edges; it is sampled like any other source.
  dtu_edge_sync u_hrc (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .src_in(internal_high_rc_osc),
    .fall_sel(1'b0),
    .level_out(),
    .edge_pulse(hrc_edge)
  );

  always_comb begin
    if (!up_timer_src_sel) begin
      up_src_tick = instr_clk_tick;
    end else if (!up_timer_lowclk_sel) begin
      up_src_tick = up_timer_edge_sel ? pin_fall_edge : pin_rise_edge;
    end else begin
      up_src_tick = up_timer_edge_sel ? lrc_fall_edge : lrc_rise_edge;
    end
  end

  // Write of 0 to the assign bit clears the shared prescaler.
  assign pre_clear = wr_low_lane && (avs_address == OFS_UP_MODE[5:0]) &&
                     !avs_writedata[BIT_PRE_ASSIGN];

  dtu_prescaler #(
    .WIDTH(8)
  ) u_shared_pre (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .clear(pre_clear),
    .ratio(shared_prescaler_ratio),
    .tick_in(up_src_tick),
    .tick_out(up_pre_tick),
    .count()
  );

  assign shared_prescaler_tick = up_pre_tick;
  assign up_tick = shared_prescaler_assign ? up_src_tick : up_pre_tick;

  always_comb begin
    if (down_timer_hirc_sel) begin
      down_src_tick = hrc_edge;
    end else if (down_timer_src_sel) begin
      down_src_tick = down_timer_edge_sel ? pin_fall_edge : pin_rise_edge;
    end else begin
      down_src_tick = instr_clk_tick;
    end
  end

  dtu_prescaler #(
    .WIDTH(8)
  ) u_down_pre (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .clear(!down_timer_run),
    .ratio(down_prescaler_ratio),
    .tick_in(down_src_tick),
    .tick_out(down_pre_tick),
    .count(down_prescaler_count)
  );

  assign down_tick = down_prescaler_en_n ? down_src_tick : down_pre_tick;

  // Control registers.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      power_ctrl_reg <= RST_POWER_CTRL;
      up_timer_mode_reg <= RST_UP_MODE;
      down_timer_ctrl_a <= RST_DOWN_CTRL_A;
      down_timer_ctrl_b <= RST_DOWN_CTRL_B;
      reload_high_bits <= 8'h00;
      down_reload_low <= 8'h00;
      irq_enable_reg <= 8'h00;
    end else if (wr_low_lane) begin
      case (avs_address)
        OFS_POWER_CTRL[5:0]: power_ctrl_reg <= avs_writedata[7:0];
        OFS_UP_MODE[5:0]: up_timer_mode_reg <= avs_writedata[7:0];
        OFS_DOWN_CTRL_A[5:0]: down_timer_ctrl_a <= avs_writedata[7:0];
        OFS_DOWN_CTRL_B[5:0]: down_timer_ctrl_b <= avs_writedata[7:0];
        OFS_RELOAD_HIGH[5:0]: reload_high_bits <= avs_writedata[7:0];
        OFS_RELOAD_LOW[5:0]: down_reload_low <= avs_writedata[7:0];
        OFS_IRQ_ENABLE: irq_enable_reg <= avs_writedata[7:0];
        default: ;
      endcase
    end
  end

  // Up counter.
  assign up_ovf = up_timer_run && up_tick && (up_count_reg == 8'hff);

  always_comb begin
    up_count_next = up_count_reg;
    if (wr_low_lane && (avs_address == OFS_UP_COUNT[5:0])) begin
      up_count_next = avs_writedata[7:0];
    end else if (up_timer_run && up_tick) begin
      up_count_next = up_count_reg + 8'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      up_count_reg <= 8'h00;
    end else begin
      up_count_reg <= up_count_next;
    end
  end

  // The low byte write commits the 10-bit reload; high bits must already be in place.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      reload_buf_reg <= 10'h000;
    end else if (wr_low_lane && (avs_address == OFS_RELOAD_LOW[5:0])) begin
      reload_buf_reg <= {reload_high_bits[BIT_RLD_HI+1:BIT_RLD_HI], avs_writedata[7:0]};
    end
  end

  // Down counter.
  assign down_unf = down_timer_run && !down_done_reg && down_tick &&
                    (down_count_reg == 10'h000);
  assign down_timer_unf = down_unf;

  always_comb begin
    down_count_next = down_count_reg;
    if (wr_low_lane && (avs_address == OFS_RELOAD_LOW[5:0]) && !down_timer_run) begin
      down_count_next = {reload_high_bits[BIT_RLD_HI+1:BIT_RLD_HI], avs_writedata[7:0]};
    end else if (down_unf) begin
      if (down_timer_oneshot) begin
        down_count_next = 10'h000;
      end else if (down_timer_reload_sel) begin
        down_count_next = reload_buf_reg;
      end else begin
        down_count_next = DOWN_FULL_SCALE;
      end
    end else if (down_timer_run && !down_done_reg && down_tick) begin
      down_count_next = down_count_reg - 10'h001;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      down_count_reg <= 10'h000;
      down_done_reg <= 1'b0;
    end else begin
      down_count_reg <= down_count_next;
      if (!down_timer_run) begin
        down_done_reg <= 1'b0;
      end else if (down_unf && down_timer_oneshot) begin
        down_done_reg <= 1'b1;
      end
    end
  end

  // Interrupt flags: an event in the clearing cycle wins.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      irq_flag_reg <= 8'h00;
    end else begin
      if (wr_low_lane && (avs_address == OFS_IRQ_FLAG[5:0])) begin
        irq_flag_reg <= irq_flag_reg & avs_writedata[7:0];
      end
      if (up_ovf) begin
        irq_flag_reg[BIT_IRQ_UP] <= 1'b1;
      end
      if (down_unf) begin
        irq_flag_reg[BIT_IRQ_DOWN] <= 1'b1;
      end
    end
  end

  assign up_timer_irq = irq_flag_reg[BIT_IRQ_UP] & irq_enable_reg[BIT_IRQ_UP] &
                        global_irq_en;
  assign down_timer_irq = irq_flag_reg[BIT_IRQ_DOWN] & irq_enable_reg[BIT_IRQ_DOWN] &
                          global_irq_en;

  // Read data, captured on the request cycle; unmapped offsets read zero.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= 32'h0000_0000;
    end else if (avs_read && !ack_reg) begin
      case (avs_address)
        OFS_POWER_CTRL[5:0]: rdata_reg <= {24'h000000, power_ctrl_reg};
        OFS_UP_MODE[5:0]: rdata_reg <= {24'h000000, up_timer_mode_reg};
        OFS_UP_COUNT[5:0]: rdata_reg <= {24'h000000, up_count_reg};
        OFS_DOWN_CTRL_A[5:0]: rdata_reg <= {24'h000000, down_timer_ctrl_a};
        OFS_DOWN_CTRL_B[5:0]: rdata_reg <= {24'h000000, down_timer_ctrl_b};
        OFS_RELOAD_HIGH[5:0]: rdata_reg <= {24'h000000, reload_high_bits};
        OFS_RELOAD_LOW[5:0]: rdata_reg <= {22'h0, down_count_reg};
        OFS_DOWN_PRE_CNT[5:0]: rdata_reg <= {24'h000000, down_prescaler_count};
        OFS_IRQ_FLAG[5:0]: rdata_reg <= {24'h000000, irq_flag_reg};
        OFS_IRQ_ENABLE: rdata_reg <= {24'h000000, irq_enable_reg};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end
endmodule : dtu_timer_unit

/* File: sim/dtu_clk_model.sv */
// Model of the pin clock and the oscillator clocks that feed the timer unit.
// Assumes the bench asks for single pin steps and for oscillator bursts.
module dtu_clk_model (
  // Requests from the bench.
  input wire logic pin_step,
  input wire logic osc_burst,
  // Clock levels.
  output logic pin,
  output logic osc
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    pin = 1'b0;
    osc = 1'b0;
  end
  // The pin stands still between requests so every count stays exact.
  always @(posedge pin_step) begin
    #3 pin = ~pin;
  end
  // A burst of sixteen 70 ns periods whose rising edges land on sys_clk falling edges and falling edges on rising ones.
  always @(posedge osc_burst) begin
    repeat (16) begin
      #35 osc = 1'b1;
      #35 osc = 1'b0;
    end
  end
endmodule : dtu_clk_model

/* File: sim/dtu_timer_unit_asserts.sv */
// Checker for the bus handshake, read data and interrupt outputs of the timer unit.
// Assumes it is bound to dtu_timer_unit and sees only its ports.
module dtu_timer_unit_asserts (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic nrst,
  // Bus.
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Outputs.
  input wire logic up_timer_irq,
  input wire logic down_timer_irq,
  input wire logic down_timer_unf,
  input wire logic shared_prescaler_tick
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  logic acc;
  logic cfg_wr;
  logic rd_done;
  assign acc = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign cfg_wr = acc && (avs_address == 6'h00 || avs_address == 6'h24 || avs_address == 6'h20);
  assign rd_done = avs_read && !avs_waitrequest;
  a_wait_one_state: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held too long");
  a_idle_no_wait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest without request");
  a_read_upper_zero: assert property (rd_done |-> avs_readdata[31:10] == 22'h0 &&
    (avs_address == 6'h18 || avs_readdata[9:8] == 2'h0)) else $error("read data upper bits set");
  a_read_unmapped: assert property (rd_done && avs_address > 6'h24 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_gie_gates_irq: assert property (acc && avs_address == 6'h00 && !avs_writedata[7]
    |=> !up_timer_irq && !down_timer_irq) else $error("irq without global enable");
  a_up_flag_holds: assert property (up_timer_irq && !cfg_wr |=> up_timer_irq)
    else $error("up irq dropped by itself");
  a_dn_flag_holds: assert property (down_timer_irq && !cfg_wr |=> down_timer_irq)
    else $error("down irq dropped by itself");
  a_dn_irq_cause: assert property ($rose(down_timer_irq) |-> $past(down_timer_unf) || $past(cfg_wr))
    else $error("down irq rose without cause");
  a_psc_tick_gap: assert property (shared_prescaler_tick |=> !shared_prescaler_tick)
    else $error("prescaler ticks too close");
endmodule : dtu_timer_unit_asserts

bind dtu_timer_unit dtu_timer_unit_asserts i_chk (.sys_clk(sys_clk), .nrst(nrst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .up_timer_irq(up_timer_irq), .down_timer_irq(down_timer_irq),
  .down_timer_unf(down_timer_unf), .shared_prescaler_tick(shared_prescaler_tick));

/* File: sim/testbench.sv */
// Self-checking bench for the dual timer unit, driven through its Avalon-MM slave.
// Assumes dtu_clk_model for pin and oscillator clocks and the bound checker.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, nrst, rd, wr, wait_req, tck, step, burst, pin, osc;
  logic up_irq, dn_irq, unf, ptick;
  logic [5:0] adr;
  logic [31:0] wdat, rdat, got;
  logic [3:0] be;
  logic [9:0] v;
  int n_errors, n_compared, base;
  int n_unf = 0;
  logic [5:0] ra [10] = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h14, 6'h18, 6'h1c, 6'h24, 6'h3c};
  logic [7:0] rv [10] = '{8'h00, 8'h08, 8'h00, 8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  dtu_timer_unit i_dut (.sys_clk(sys_clk), .nrst(nrst), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
    .avs_waitrequest(wait_req), .instr_clk_tick(tck), .ext_timer_clk_pin(pin),
    .internal_low_rc_osc(osc), .internal_high_rc_osc(osc), .up_timer_irq(up_irq),
    .down_timer_irq(dn_irq), .down_timer_unf(unf), .shared_prescaler_tick(ptick));
  dtu_clk_model i_clk (.pin_step(step), .osc_burst(burst), .pin(pin), .osc(osc));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (unf === 1'b1) n_unf <= n_unf + 1;
  task automatic print_verdict();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  // Each request stands until the edge that samples waitrequest low; read data is taken there.
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d,
                     input logic b = 1'b1);
    int n = 0;
    @(posedge sys_clk);
    adr <= a;
    wr <= w;
    rd <= !w;
    wdat <= {24'h0, d};
    be <= {3'h0, b};
    do begin
      @(posedge sys_clk);
      n++;
    end while (wait_req !== 1'b0 && n < 50);
    got = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (wait_req !== 1'b0) begin
      n_errors++;
      $display("BAD %0t bus wait timed out", $time);
      print_verdict();
    end
  endtask : bus
  task automatic rdc(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 8'h00);
    chk(got, e);
  endtask : rdc
  task automatic flag_chk(input int which, input logic e);
    @(negedge sys_clk);
    chk({31'h0, which ? dn_irq : up_irq}, {31'h0, e});
  endtask : flag_chk
  task automatic ticks(input int k);
    repeat (k) begin
      @(posedge sys_clk);
      tck <= 1'b1;
      @(posedge sys_clk);
      tck <= 1'b0;
      repeat ($urandom_range(2, 0)) @(posedge sys_clk);
    end
  endtask : ticks
  task automatic pulse_pin();
    step <= 1'b1;
    @(posedge sys_clk);
    step <= 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask : pulse_pin
  task automatic osc_run();
    burst <= 1'b1;
    @(posedge sys_clk);
    burst <= 1'b0;
    repeat (130) @(posedge sys_clk);
  endtask : osc_run
  initial begin
    {nrst, rd, wr, tck, step, burst} = 6'h0;
    adr = 6'h0;
    wdat = 32'h0;
    be = 4'h0;
    n_errors = 0;
    n_compared = 0;
    void'($urandom(32'ha61d));
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 10; i++) rdc(ra[i], {24'h0, rv[i]});
    v = 10'($urandom);
    bus(1'b1, 6'h08, v[7:0]);
    rdc(6'h08, {24'h0, v[7:0]});
    bus(1'b1, 6'h08, ~v[7:0], 1'b0);
    ticks(3);
    rdc(6'h08, {24'h0, v[7:0]});
    bus(1'b1, 6'h00, 8'h01);
    ticks(3);
    bus(1'b1, 6'h00, 8'h00);
    rdc(6'h08, {24'h0, v[7:0] + 8'h03});
    for (int r = 0; r < 8; r++) begin
      bus(1'b1, 6'h04, 8'(r));
      bus(1'b1, 6'h08, 8'h00);
      bus(1'b1, 6'h00, 8'h01);
      ticks((2 << r) * 2 - 1);
      bus(1'b1, 6'h00, 8'h00);
      rdc(6'h08, 32'h1);
    end
    bus(1'b1, 6'h04, 8'h08);
    bus(1'b1, 6'h08, 8'hff);
    bus(1'b1, 6'h20, 8'h09);
    bus(1'b1, 6'h00, 8'h81);
    ticks(1);
    bus(1'b1, 6'h00, 8'h80);
    flag_chk(0, 1'b1);
    rdc(6'h08, 32'h0);
    repeat (20) @(posedge sys_clk);
    flag_chk(0, 1'b1);
    bus(1'b1, 6'h00, 8'h00);
    flag_chk(0, 1'b0);
    bus(1'b1, 6'h00, 8'h80);
    flag_chk(0, 1'b1);
    bus(1'b1, 6'h24, 8'hfe);
    flag_chk(0, 1'b0);
    for (int e = 0; e < 2; e++) begin
      bus(1'b1, 6'h04, 8'h28 | 8'(e << 4));
      bus(1'b1, 6'h08, 8'h00);
      bus(1'b1, 6'h00, 8'h81);
      pulse_pin();
      rdc(6'h08, 32'(e == 0));
      pulse_pin();
      rdc(6'h08, 32'h1);
      bus(1'b1, 6'h00, 8'h80);
      if (e == 1) rdc(6'h18, 32'h0ff);
      bus(1'b1, 6'h10, 8'h28 | 8'(e << 4));
      bus(1'b1, 6'h14, 8'h10);
      bus(1'b1, 6'h18, 8'h00);
      bus(1'b1, 6'h0c, 8'h01);
      pulse_pin();
      rdc(6'h18, 32'h100 - 32'(e == 0));
      pulse_pin();
      rdc(6'h18, 32'h0ff);
      bus(1'b1, 6'h0c, 8'h00);
    end
    bus(1'b1, 6'h04, 8'ha2);
    bus(1'b1, 6'h08, 8'h00);
    bus(1'b1, 6'h00, 8'h81);
    osc_run();
    bus(1'b1, 6'h00, 8'h80);
    rdc(6'h08, 32'h2);
    bus(1'b1, 6'h10, 8'h08);
    bus(1'b1, 6'h18, 8'h00);
    bus(1'b1, 6'h0c, 8'h09);
    osc_run();
    bus(1'b1, 6'h0c, 8'h08);
    rdc(6'h18, 32'h0f0);
    v = 10'($urandom);
    bus(1'b1, 6'h0c, 8'h00);
    bus(1'b1, 6'h14, {2'b00, v[9:8], 4'h0});
    bus(1'b1, 6'h18, v[7:0]);
    rdc(6'h18, {22'h0, v});
    v = 10'($urandom_range(9, 2));
    bus(1'b1, 6'h14, 8'h00);
    bus(1'b1, 6'h18, v[7:0]);
    bus(1'b1, 6'h20, 8'h08);
    base = n_unf;
    bus(1'b1, 6'h0c, 8'h05);
    ticks(int'(v) + 3);
    chk(32'(n_unf - base), 32'h1);
    rdc(6'h18, 32'h0);
    flag_chk(1, 1'b1);
    bus(1'b1, 6'h24, 8'hf7);
    flag_chk(1, 1'b0);
    bus(1'b1, 6'h0c, 8'h00);
    bus(1'b1, 6'h18, 8'h04);
    bus(1'b1, 6'h0c, 8'h03);
    ticks(2);
    bus(1'b1, 6'h18, 8'h06);
    rdc(6'h18, 32'h2);
    ticks(3);
    rdc(6'h18, 32'h6);
    bus(1'b1, 6'h0c, 8'h01);
    ticks(7);
    rdc(6'h18, 32'h3ff);
    bus(1'b1, 6'h0c, 8'h00);
    bus(1'b1, 6'h10, 8'h01);
    bus(1'b1, 6'h18, 8'h10);
    bus(1'b1, 6'h0c, 8'h01);
    ticks(6);
    rdc(6'h18, 32'h0f);
    rdc(6'h1c, 32'h6);
    print_verdict();
  end
endmodule : testbench
